// file: bench/dram_host_checker.sv
// Pin protocol checker for the DRAM host controller
`timescale 1ns/1ps
`default_nettype none
module dram_host_checker #(
    parameter int POWERUP_PAUSE_CYC = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_ready,
    input wire logic init_done,
    input wire logic resp_valid,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic data_pins_oe
);
    // ------------
    // Pause counter
    // ------------
    int age;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            age <= 0;
        end else if (clk_en && age < POWERUP_PAUSE_CYC) begin
            age <= age + 1;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    pause_strobes_a: assert property (age + 1 < POWERUP_PAUSE_CYC
        |-> row_strobe_n && column_strobe_n) else $error("strobe in pause");
    ready_gate_a: assert property (!init_done |-> !req_ready)
        else $error("ready before init");
    cbr_setup_a: assert property ($fell(row_strobe_n) && !column_strobe_n
        |-> !$past(column_strobe_n)) else $error("no column setup");
    ras_width_a: assert property ($fell(row_strobe_n) |-> !row_strobe_n[*2])
        else $error("row strobe too short");
    precharge_a: assert property ($rose(row_strobe_n) |-> row_strobe_n[*2])
        else $error("precharge too short");
    write_latch_a: assert property ($fell(column_strobe_n) && !write_enable_n
        || $fell(write_enable_n) && !column_strobe_n |-> data_pins_oe) else $error("no data");
    host_drive_a: assert property (data_pins_oe && !column_strobe_n |-> !write_enable_n)
        else $error("drive in read");
    resp_pulse_a: assert property (resp_valid |=> !resp_valid)
        else $error("long response");
    resp_source_a: assert property ($rose(resp_valid)
        |-> !$past(column_strobe_n) && !$past(output_enable_n)) else $error("bad sample");
endmodule : dram_host_checker
bind dram_host_ctrl dram_host_checker #(.POWERUP_PAUSE_CYC(POWERUP_PAUSE_CYC)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req_ready(req_ready),
    .init_done(init_done), .resp_valid(resp_valid), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .data_pins_oe(data_pins_oe));
`default_nettype wire

// file: bench/dram_host_ctrl_tb.sv
// Self-checking testbench for the DRAM host controller
`timescale 1ns/1ps
`default_nettype none
module dram_host_ctrl_tb;
    import dram_host_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    cmd_t req_cmd = CMD_READ;
    logic [8:0] req_row = 9'h000;
    logic [8:0] req_col = 9'h000;
    logic [3:0] req_wdata = 4'h0;
    logic req_ready, resp_valid, init_done, row_strobe_n, column_strobe_n, write_enable_n;
    logic output_enable_n, data_pins_oe, dev_drive;
    logic [8:0] address_pins;
    logic [3:0] resp_rdata, data_pins_out, dev_data, data_pins_in, got;
    int mismatches = 0;
    int checked = 0;
    int seen;
    always #25 core_clk = ~core_clk;
    assign data_pins_in = data_pins_oe ? data_pins_out : dev_drive ? dev_data : ~dev_data;
    dram_host_ctrl #(.REFRESH_INTERVAL_CYC(64), .POWERUP_PAUSE_CYC(20)) u_dram_host_ctrl (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
        .req_ready(req_ready), .req_cmd(req_cmd), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .init_done(init_done), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
        .address_pins(address_pins), .data_pins_in(data_pins_in),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
    dram_model u_dram_model (.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
        .address_pins(address_pins), .host_data(data_pins_out), .dev_data(dev_data),
        .dev_drive(dev_drive));
    // ------------
    // Shared tasks
    // ------------
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
        checked++;
        if (got_v !== exp_v) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got_v, exp_v);
        end
    endtask : chk
    task automatic op(input cmd_t c, input logic [8:0] r, input logic [8:0] k,
        input logic [3:0] w);
        @(posedge core_clk);
        req_cmd <= c;
        req_row <= r;
        req_col <= k;
        req_wdata <= w;
        req_valid <= 1'b1;
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        if (c inside {CMD_READ, CMD_RMW, CMD_COUNTER_TEST}) begin
            do @(posedge core_clk); while (resp_valid !== 1'b1);
            got = resp_rdata;
        end
    endtask : op
    // ------------
    // Scenarios
    // ------------
    task automatic t_page();
        op(CMD_WRITE, 9'h005, 9'h000, 4'hA);
        op(CMD_WRITE, 9'h005, 9'h1FF, 4'h5);
        op(CMD_WRITE, 9'h1FF, 9'h000, 4'h3);
        op(CMD_READ, 9'h005, 9'h000, 4'h0);
        chk(16'(got), 16'h000A);
        op(CMD_READ, 9'h005, 9'h1FF, 4'h0);
        chk(16'(got), 16'h0005);
        op(CMD_READ, 9'h1FF, 9'h000, 4'h0);
        chk(16'(got), 16'h0003);
    endtask : t_page
    task automatic t_rmw_and_test();
        op(CMD_RMW, 9'h005, 9'h000, 4'h9);
        chk(16'(got), 16'h000A);
        op(CMD_READ, 9'h005, 9'h000, 4'h0);
        chk(16'(got), 16'h0009);
        op(CMD_ROW_REFRESH, 9'h1AB, 9'h000, 4'h0);
        op(CMD_COUNTER_TEST, 9'h000, 9'h055, 4'hF);
        chk(16'(got), 16'h0000);
        chk(16'(u_dram_model.ras_only_row), 16'h01AB);
        chk(16'(u_dram_model.hit[8:0]), 16'h0055);
        @(posedge core_clk);
        chk(16'(u_dram_model.mem[u_dram_model.hit]), 16'h000F);
        op(CMD_READ, 9'h000, 9'h055, 4'h0);
        chk(16'(got), 16'h0000);
    endtask : t_rmw_and_test
    task automatic t_refresh();
        seen = u_dram_model.refreshes;
        repeat (200) @(posedge core_clk);
        chk(16'(u_dram_model.refreshes - seen >= 3), 16'h0001);
        clk_en <= 1'b0;
        @(posedge core_clk);
        seen = u_dram_model.refreshes;
        repeat (200) @(posedge core_clk);
        chk(16'(u_dram_model.refreshes), 16'(seen));
        clk_en <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            op(CMD_READ, 9'h005, 9'h1FF, 4'h0);
            chk(16'(got), 16'h0005);
        end
    endtask : t_refresh
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        wait (init_done === 1'b1);
        chk(16'(u_dram_model.refreshes), 16'h0008);
        t_page();
        t_rmw_and_test();
        t_refresh();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end
endmodule : dram_host_ctrl_tb
`default_nettype wire

// file: bench/dram_model.sv
// Behavioural model of the page-mode DRAM device
`timescale 1ns/1ps
`default_nettype none
module dram_model #(
    parameter int ACCESS_NS = 20
) (
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic [8:0] address_pins,
    input wire logic [3:0] host_data,
    output logic [3:0] dev_data,
    output logic dev_drive
);
    // ------------
    // Cell array
    // ------------
    logic [3:0] mem [logic [17:0]];
    logic [8:0] row, col, ras_only_row;
    logic [8:0] counter = 9'h000;
    logic [17:0] hit;
    logic active = 1'b0;
    logic early = 1'b0;
    int refreshes = 0;
    always @(negedge row_strobe_n) begin
        if (!column_strobe_n) begin
            row = counter;
            counter = counter + 9'h001;
            refreshes++;
        end else begin
            row = address_pins;
            ras_only_row = address_pins;
        end
    end
    always @(negedge column_strobe_n) begin
        active = !row_strobe_n;
        col = address_pins;
        early = !write_enable_n;
        if (active) hit = {row, col};
        if (active && early) mem[{row, col}] = host_data;
        dev_data = mem.exists({row, col}) ? mem[{row, col}] : 4'h0;
    end
    always @(negedge write_enable_n) begin
        if (active && !column_strobe_n && !early) mem[{row, col}] = host_data;
    end
    always @(posedge column_strobe_n) active = 1'b0;
    assign #ACCESS_NS dev_drive = active && !early && !output_enable_n;
endmodule : dram_model
`default_nettype wire

// file: rtl/dram_host_ctrl.sv
// Host sequencer for an asynchronous fast-page-mode DRAM with refresh
//
// How it works
// RULE_01 - One refresh per 8.2 ms / 512 interval.
// RULE_02 - Row-only refresh: row low, column high.
// RULE_03 - Data floats in row-only refresh.
// RULE_04 - Column before row strobe: counter refresh.
// RULE_05 - Device counter steps per counter refresh.
// RULE_06 - Second column fall opens counter test access.
// RULE_07 - Counter test row from device counter.
// RULE_08 - Counter test column at second column fall.
// RULE_09 - Page mode: row low, column strobe per access.
// RULE_10 - Data sampled after slowest access path.
// RULE_11 - Data floats once column or output enable rises.
// RULE_12 - Hidden refresh keeps read data driven.
// RULE_13 - Page accesses do not refresh.
// RULE_14 - 200 us pause, then eight counter refreshes.
// RULE_15 - Counter test after eight refreshes, one column.
// RULE_16 - Counter test cycle is read-modify-write.
// RULE_17 - Write enable high until column rises on reads.
// RULE_18 - Data floats in early write.
// RULE_19 - Hidden refresh: column low, row cycled high-low.
// RULE_20 - Row at row fall, column at column fall.
// RULE_21 - Write enable low writes, high reads.
// RULE_22 - Data latched at later of write and column fall.
// RULE_23 - Data floats until column falls in a read.
`timescale 1ns/1ps
`default_nettype none
module dram_host_ctrl #(
    parameter int REFRESH_INTERVAL_CYC = dram_host_pkg::REFRESH_INTERVAL_CYC,
    parameter int POWERUP_PAUSE_CYC = dram_host_pkg::POWERUP_PAUSE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire dram_host_pkg::cmd_t req_cmd,
    input wire logic [dram_host_pkg::ADDR_W-1:0] req_row,
    input wire logic [dram_host_pkg::ADDR_W-1:0] req_col,
    input wire logic [dram_host_pkg::DATA_W-1:0] req_wdata,
    output logic resp_valid,
    output logic [dram_host_pkg::DATA_W-1:0] resp_rdata,
    output logic init_done,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic write_enable_n,
    output logic output_enable_n,
    output logic [dram_host_pkg::ADDR_W-1:0] address_pins,
    input wire logic [dram_host_pkg::DATA_W-1:0] data_pins_in,
    output logic [dram_host_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe
);
    import dram_host_pkg::*;

    if (REFRESH_INTERVAL_CYC < 32 || ACCESS_CYC >= 2 ** CNT_W || RP_CYC >= 2 ** CNT_W
            || RAS_CYC >= 2 ** CNT_W || RAS_MAX_CYC >= 2 ** AGE_W) begin : g_bad_param
        $error("dram_host_ctrl: timing counts out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [14:0] {
        S_PAUSE = 15'h0001,
        S_IDLE = 15'h0002,
        S_START = 15'h0004,
        S_ROW = 15'h0008,
        S_COLSET = 15'h0010,
        S_CAS = 15'h0020,
        S_RMW_OE = 15'h0040,
        S_RMW_WR = 15'h0080,
        S_CP = 15'h0100,
        S_HIDDEN = 15'h0200,
        S_CBR_CAS = 15'h0400,
        S_REF_RAS = 15'h0800,
        S_CTR_CP = 15'h1000,
        S_RAS_ONLY = 15'h2000,
        S_PRE = 15'h4000
    } seq_t;

    typedef struct packed {
        seq_t st;
        logic [CNT_W-1:0] cnt;
        logic [AGE_W-1:0] age;
        logic [INIT_W-1:0] init_left;
        logic row_open;
        logic pending;
        logic init_done;
        logic req_ready;
        logic resp_valid;
        logic ack;
        cmd_t cmd;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{st: S_PAUSE, cnt: '0, age: '0,
        init_left: INIT_W'(INIT_CYCLES), row_open: 1'b0, pending: 1'b0, init_done: 1'b0,
        req_ready: 1'b0, resp_valid: 1'b0, ack: 1'b0, cmd: CMD_READ, row: '0, col: '0,
        wdata: '0, rdata: '0, ras_n: STROBE_OFF, cas_n: STROBE_OFF, we_n: STROBE_OFF,
        oe_n: STROBE_OFF, addr: '0, dq_out: '0, dq_oe: 1'b0};

    localparam logic [AGE_W-1:0] AGE_LIMIT = AGE_W'(RAS_MAX_CYC - PAGE_MARGIN_CYC);

    ctrl_t r;
    ctrl_t next_r;
    logic done;
    logic too_old;
    refresh_if rif();

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [CNT_W-1:0] load(input int n);
        return CNT_W'(n - 1);
    endfunction : load

    function automatic ctrl_t col_setup(input ctrl_t s);
        ctrl_t o;
        o = s;
        o.addr = s.col; // [RULE_20] [RULE_08]
        o.dq_oe = (s.cmd == CMD_WRITE);
        o.we_n = o.dq_oe ? STROBE_ON : STROBE_OFF; // [RULE_21] [RULE_22]
        o.oe_n = o.dq_oe ? STROBE_OFF : STROBE_ON;
        o.dq_out = s.wdata;
        o.st = S_COLSET;
        return o;
    endfunction : col_setup

    function automatic ctrl_t close_row(input ctrl_t s);
        ctrl_t o;
        o = s;
        o.ras_n = STROBE_OFF;
        o.cas_n = STROBE_OFF;
        o.oe_n = STROBE_OFF;
        o.row_open = 1'b0;
        o.cnt = load(RP_CYC);
        o.st = S_PRE;
        return o;
    endfunction : close_row

    function automatic ctrl_t end_col(input ctrl_t s);
        ctrl_t o;
        o = s;
        o.cas_n = STROBE_OFF;
        o.we_n = STROBE_OFF;
        o.oe_n = STROBE_OFF;
        o.dq_oe = 1'b0;
        o.cnt = load(CP_CYC);
        o.st = S_CP;
        return o;
    endfunction : end_col

    function automatic ctrl_t start_cbr(input ctrl_t s);
        ctrl_t o;
        o = s;
        o.cas_n = STROBE_ON; // [RULE_04]
        o.cnt = load(CSR_CYC);
        o.st = S_CBR_CAS;
        return o;
    endfunction : start_cbr

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.resp_valid = 1'b0;
        next_r.ack = 1'b0;
        done = (r.cnt == '0);
        too_old = r.row_open && (r.age >= AGE_LIMIT);
        if (r.cnt != '0) begin
            next_r.cnt = r.cnt - CNT_W'(1);
        end
        if (r.row_open && r.age != '1) begin
            next_r.age = r.age + AGE_W'(1);
        end
        unique case (r.st)
            S_PAUSE: begin
                if (rif.pause_done) begin
                    next_r = start_cbr(r); // [RULE_14]
                end
            end
            S_IDLE: begin
                if (r.req_ready && req_valid) begin
                    next_r.cmd = req_cmd;
                    next_r.row = req_row;
                    next_r.col = req_col;
                    next_r.wdata = req_wdata;
                    if (r.row_open && req_row == r.row && !too_old
                            && (req_cmd == CMD_READ || req_cmd == CMD_WRITE)) begin
                        next_r = col_setup(next_r); // [RULE_09]
                    end else if (r.row_open) begin
                        next_r.pending = 1'b1;
                        next_r = close_row(next_r);
                    end else begin
                        next_r.pending = 1'b1;
                        next_r.st = S_START;
                    end
                end else if (rif.due || too_old) begin
                    next_r = r.row_open ? close_row(r) : start_cbr(r); // [RULE_01]
                end
            end
            S_START: begin
                if (r.cmd == CMD_ROW_REFRESH) begin
                    next_r.pending = 1'b0;
                    next_r.addr = r.row;
                    next_r.ras_n = STROBE_ON; // [RULE_02] [RULE_03]
                    next_r.cnt = load(RAS_CYC);
                    next_r.st = S_RAS_ONLY;
                end else if (r.cmd == CMD_COUNTER_TEST) begin
                    next_r = start_cbr(r); // [RULE_06] [RULE_15]
                end else begin
                    next_r.pending = 1'b0;
                    next_r.addr = r.row; // [RULE_20]
                    next_r.ras_n = STROBE_ON;
                    next_r.row_open = 1'b1;
                    next_r.age = '0;
                    next_r.cnt = load(RCD_CYC);
                    next_r.st = S_ROW;
                end
            end
            S_ROW: begin
                if (done) begin
                    next_r = col_setup(next_r);
                end
            end
            S_COLSET: begin
                next_r.cas_n = STROBE_ON;
                next_r.cnt = load(ACCESS_CYC); // [RULE_10]
                next_r.st = S_CAS;
            end
            S_CAS: begin
                if (done) begin
                    if (r.cmd == CMD_WRITE) begin
                        next_r = end_col(next_r);
                    end else begin
                        next_r.rdata = data_pins_in; // [RULE_10]
                        next_r.resp_valid = 1'b1;
                        if (r.cmd == CMD_READ && rif.due) begin
                            next_r.ras_n = STROBE_OFF; // [RULE_19] [RULE_12]
                            next_r.cnt = load(RP_CYC);
                            next_r.st = S_HIDDEN;
                        end else if (r.cmd == CMD_READ) begin
                            next_r = end_col(next_r); // [RULE_17]
                        end else begin
                            next_r.oe_n = STROBE_OFF;
                            next_r.cnt = load(OED_CYC);
                            next_r.st = S_RMW_OE;
                        end
                    end
                end
            end
            S_RMW_OE: begin
                if (done) begin
                    next_r.we_n = STROBE_ON; // [RULE_22] [RULE_16]
                    next_r.dq_oe = 1'b1;
                    next_r.dq_out = r.wdata;
                    next_r.cnt = load(WP_CYC);
                    next_r.st = S_RMW_WR;
                end
            end
            S_RMW_WR: begin
                if (done) begin
                    next_r = end_col(next_r);
                end
            end
            S_CP: begin
                if (done) begin
                    next_r.st = S_IDLE;
                    if (r.cmd == CMD_COUNTER_TEST) begin
                        next_r = close_row(r);
                    end
                end
            end
            S_HIDDEN: begin
                if (done) begin
                    next_r.ras_n = STROBE_ON; // [RULE_19]
                    next_r.row_open = 1'b0;
                    next_r.cnt = load(RAS_CYC);
                    next_r.st = S_REF_RAS;
                end
            end
            S_CBR_CAS: begin
                if (done) begin
                    next_r.ras_n = STROBE_ON; // [RULE_04]
                    next_r.cnt = load(RAS_CYC);
                    next_r.st = S_REF_RAS;
                end
            end
            S_REF_RAS: begin
                if (done) begin
                    next_r.ack = 1'b1; // [RULE_05]
                    if (r.init_left != '0) begin
                        next_r.init_left = r.init_left - INIT_W'(1);
                    end
                    if (r.pending) begin
                        next_r.pending = 1'b0;
                        next_r.cas_n = STROBE_OFF; // [RULE_06]
                        next_r.cnt = load(CP_CYC);
                        next_r.st = S_CTR_CP;
                    end else begin
                        next_r = close_row(next_r);
                    end
                end
            end
            S_CTR_CP: begin
                if (done) begin
                    next_r = col_setup(next_r); // [RULE_07] [RULE_08]
                end
            end
            S_RAS_ONLY: begin
                if (done) begin
                    next_r = close_row(r); // [RULE_02]
                end
            end
            S_PRE: begin
                if (done) begin
                    if (r.init_left != '0) begin
                        next_r = start_cbr(r); // [RULE_14]
                    end else begin
                        next_r.init_done = 1'b1;
                        next_r.st = r.pending ? S_START : S_IDLE;
                    end
                end
            end
            default: begin
                next_r = close_row(CTRL_RESET);
            end
        endcase
        next_r.req_ready = (next_r.st == S_IDLE) && next_r.init_done && !rif.due;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= CTRL_RESET;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Timer
    // ----------------------------------------------------------------
    assign rif.ack = r.ack;

    refresh_timer #(
        .INTERVAL_CYC(REFRESH_INTERVAL_CYC),
        .PAUSE_CYC(POWERUP_PAUSE_CYC)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .rif(rif.timer)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign req_ready = r.req_ready;
    assign resp_valid = r.resp_valid;
    assign resp_rdata = r.rdata;
    assign init_done = r.init_done;
    assign row_strobe_n = r.ras_n;
    assign column_strobe_n = r.cas_n;
    assign write_enable_n = r.we_n;
    assign output_enable_n = r.oe_n;
    assign address_pins = r.addr;
    assign data_pins_out = r.dq_out;
    assign data_pins_oe = r.dq_oe;

endmodule : dram_host_ctrl
`default_nettype wire

// file: rtl/dram_host_pkg.sv
// Constants, timings and command codes of the DRAM host controller
package dram_host_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 4;
    localparam int ROW_COUNT = 512;
    localparam int INIT_CYCLES = 8;
    localparam int INIT_W = 4;
    localparam int CNT_W = 4;
    localparam int AGE_W = 11;

    // ----------------------------------------------------------------
    // Pin levels
    // ----------------------------------------------------------------
    localparam logic STROBE_ON = 1'b0;
    localparam logic STROBE_OFF = 1'b1;

    // ----------------------------------------------------------------
    // Times in ns, page margin in cycles
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int REFRESH_WINDOW_NS = 8_200_000;
    localparam int POWERUP_PAUSE_NS = 200_000;
    localparam int T_RP_NS = 60;
    localparam int T_RAS_NS = 70;
    localparam int T_RAS_MAX_NS = 100_000;
    localparam int T_RCD_NS = 20;
    localparam int COLUMN_STROBE_ACCESS_NS = 20;
    localparam int COLUMN_ADDRESS_ACCESS_NS = 35;
    localparam int COLUMN_PRECHARGE_ACCESS_NS = 45;
    localparam int OUTPUT_ENABLE_ACCESS_NS = 20;
    localparam int REFRESH_COLUMN_SETUP_NS = 0;
    localparam int T_CP_NS = 10;
    localparam int T_WP_NS = 10;
    localparam int T_OED_NS = 15;
    localparam int PAGE_MARGIN_CYC = 16;

    // ----------------------------------------------------------------
    // Cycle conversion
    // ----------------------------------------------------------------
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    function automatic int cyc_dn(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_dn

    function automatic int max4(input int a, input int b, input int c, input int d);
        int m;
        m = (a > b) ? a : b;
        m = (c > m) ? c : m;
        return (d > m) ? d : m;
    endfunction : max4

    localparam int RP_CYC = cyc_up(T_RP_NS);
    localparam int RAS_CYC = cyc_up(T_RAS_NS);
    localparam int RCD_CYC = cyc_up(T_RCD_NS);
    localparam int ACCESS_CYC = cyc_up(max4(COLUMN_STROBE_ACCESS_NS, COLUMN_ADDRESS_ACCESS_NS,
        COLUMN_PRECHARGE_ACCESS_NS, OUTPUT_ENABLE_ACCESS_NS));
    localparam int CSR_CYC = cyc_up(REFRESH_COLUMN_SETUP_NS);
    localparam int CP_CYC = cyc_up(T_CP_NS);
    localparam int WP_CYC = cyc_up(T_WP_NS);
    localparam int OED_CYC = cyc_up(T_OED_NS);
    localparam int RAS_MAX_CYC = cyc_dn(T_RAS_MAX_NS);
    localparam int REFRESH_INTERVAL_CYC = cyc_dn(REFRESH_WINDOW_NS / ROW_COUNT);
    localparam int POWERUP_PAUSE_CYC = cyc_up(POWERUP_PAUSE_NS);

    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_WRITE = 3'h1,
        CMD_RMW = 3'h2,
        CMD_ROW_REFRESH = 3'h3,
        CMD_COUNTER_TEST = 3'h4
    } cmd_t;

endpackage : dram_host_pkg

// file: rtl/refresh_if.sv
// Signals between refresh timer and sequencer
`timescale 1ns/1ps
`default_nettype none
interface refresh_if;
    logic due;
    logic pause_done;
    logic ack;
    modport timer(output due, output pause_done, input ack);
    modport ctrl(input due, input pause_done, output ack);
endinterface : refresh_if
`default_nettype wire

// file: rtl/refresh_timer.sv
// Power-up pause and periodic refresh request timer
`timescale 1ns/1ps
`default_nettype none
module refresh_timer #(
    parameter int INTERVAL_CYC = dram_host_pkg::REFRESH_INTERVAL_CYC,
    parameter int PAUSE_CYC = dram_host_pkg::POWERUP_PAUSE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    refresh_if.timer rif
);
    import dram_host_pkg::*;

    localparam int TOP = (INTERVAL_CYC > PAUSE_CYC) ? INTERVAL_CYC : PAUSE_CYC;
    localparam int TW = $clog2(TOP + 1);

    if (INTERVAL_CYC < 1 || PAUSE_CYC < 1) begin : g_bad_param
        $error("refresh_timer: counts must be at least one");
    end

    typedef struct packed {
        logic [TW-1:0] cnt;
        logic paused;
        logic due;
    } timer_t;

    timer_t r;
    timer_t next_r;
    logic set_due;

    // ----------------------------------------------------------------
    // Counting
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        set_due = 1'b0;
        if (!r.paused) begin
            if (r.cnt == TW'(PAUSE_CYC - 1)) begin
                next_r.paused = 1'b1;
                next_r.cnt = '0;
            end else begin
                next_r.cnt = r.cnt + TW'(1);
            end
        end else if (r.cnt == TW'(INTERVAL_CYC - 1)) begin
            set_due = 1'b1; // [RULE_01]
            next_r.cnt = '0;
        end else begin
            next_r.cnt = r.cnt + TW'(1);
        end
        next_r.due = set_due | (r.due & ~rif.ack);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign rif.due = r.due;
    assign rif.pause_done = r.paused;

endmodule : refresh_timer
`default_nettype wire
